// File: dv/core_model.sv
// Processor core model: acknowledges vectors and keeps a small return stack
`timescale 1ns/1ps
module core_model #(
    parameter DEPTH = 2
) (
    input  wire        clk_sys,
    input  wire        reset_n,
    input  wire        irq_request,
    input  wire [2:0]  irq_vector,
    input  wire        ret_req,
    input  wire [3:0]  lag,
    output logic       irq_ack,
    output logic       stack_full,
    output logic       reti_event,
    output logic [2:0] taken_vec,
    output int         taken_cnt
);
    int depth_ff;
    int wait_ff;
    assign stack_full = depth_ff >= DEPTH;
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            {irq_ack, reti_event, taken_vec} <= 5'h0;
            depth_ff <= 0;
            wait_ff <= 0;
            taken_cnt <= 0;
        end else begin
            irq_ack <= 1'b0;
            reti_event <= ret_req && depth_ff > 0;
            if (ret_req && depth_ff > 0) begin
                depth_ff <= depth_ff - 1;
            end else if (irq_ack && irq_request) begin
                depth_ff <= depth_ff + 1;
                taken_vec <= irq_vector;
                taken_cnt <= taken_cnt + 1;
                wait_ff <= 0;
            end else if (irq_request && !irq_ack) begin
                // Slow core: the acknowledge is held off for lag cycles
                if (wait_ff >= lag) begin
                    irq_ack <= 1'b1;
                end else begin
                    wait_ff <= wait_ff + 1;
                end
            end
        end
    end
endmodule

// File: dv/irq_timebase_bench.sv
// Self-checking bench for the interrupt and time-base block
`timescale 1ns/1ps
`include "irq_timebase_regs.vh"
module irq_timebase_bench;
    logic        clk_sys = 0, reset_n = 0, hsel = 0, hwrite = 0, comparator_out = 0, converter_done = 0;
    logic        low_voltage_event = 0, eeprom_done = 0, serial_byte_done = 0, serial_addr_match = 0;
    logic        serial_timeout = 0, subsidiary_clock = 0, ret_req = 0;
    logic [31:0] haddr = 0, hwdata = 0, rv;
    logic [1:0]  htrans = 0;
    logic [2:0]  hsize = 3'h2;
    logic [5:0]  timer_match = 0;
    logic [3:0]  lag = 0;
    wire  [31:0] hrdata;
    wire  [2:0]  irq_vector, taken_vec;
    wire         hreadyout, hresp, irq_request, irq_push_pc, irq_ack, stack_full, reti_event;
    wire         hready = hreadyout;
    int          taken_cnt, err_total = 0, comparisons = 0, n, v, c, e, s, t;
    irq_timebase irq_timebase_i (.*);
    core_model core_model_i (.*);
    always #10 clk_sys = ~clk_sys;
    // Slow clock period not a multiple of the system clock, so phase drifts
    always #83 subsidiary_clock = ~subsidiary_clock;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic phase_end(output logic [31:0] d);
        logic rdy;
        do begin
            @(negedge clk_sys);
            rdy = hready;
            d = hrdata;
            @(posedge clk_sys);
        end while (rdy !== 1'b1);
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        phase_end(rv);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        phase_end(rv);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rv, exp);
    endtask
    task automatic wait_take(input int limit);
        int c0;
        c0 = taken_cnt;
        n = 0;
        while (taken_cnt == c0 && n < limit) begin
            @(posedge clk_sys);
            n++;
        end
    endtask
    task automatic ret();
        ret_req <= 1'b1;
        @(posedge clk_sys);
        ret_req <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic fire(input int k);
        case (k)
            0: comparator_out <= ~comparator_out;
            1: converter_done <= 1'b1;
            2: serial_byte_done <= 1'b1;
            3: serial_addr_match <= 1'b1;
            4: serial_timeout <= 1'b1;
            11: low_voltage_event <= 1'b1;
            12: eeprom_done <= 1'b1;
            default: timer_match[k-5] <= 1'b1;
        endcase
        @(posedge clk_sys);
        {converter_done, serial_byte_done, serial_addr_match, serial_timeout} <= 4'h0;
        {timer_match, low_voltage_event, eeprom_done} <= 8'h00;
    endtask
    function automatic int vec_of(input int k);
        if (k == 0) return `VEC_CMP;
        if (k == 1) return `VEC_ADC;
        if (k < 5) return `VEC_SER;
        if (k < 11) return ((k - 5) / 2 == 1) ? `VEC_GRP1 : `VEC_GRP0;
        return `VEC_GRP2;
    endfunction
    task automatic give_verdict();
        $display("comparisons=%0d mismatches=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clk_sys);
        err_total++;
        give_verdict();
    end
    initial begin
        rv = $urandom(32'h1B2E);
        repeat (20) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rdc(`OFS_PRESCALER0_CLOCK_SELECT, 32'h0);
        rdc(`OFS_PRESCALER1_CLOCK_SELECT, 32'h0);
        rdc(`OFS_TIME_BASE1_CONTROL, 32'h0);
        wr(`OFS_TIME_BASE0_CONTROL, 32'hFFFFFF7F);
        rdc(`OFS_TIME_BASE0_CONTROL, 32'h7);
        wr(`OFS_IRQ_ENABLE, 32'h160);
        wait_take(400);
        chk(n, 400);
        wr(`OFS_TIME_BASE0_CONTROL, 32'h0);
        wr(8'h40, 32'hFFFFFFFF);
        rdc(8'h40, 32'h0);
        $display("test registers done");
        for (int k = 0; k < 13; k++) begin
            v = vec_of(k);
            lag <= 4'($urandom % 4);
            wr(`OFS_SOURCE_ENABLE, 32'hFF);
            wr(`OFS_IRQ_ENABLE, 32'h100 | (32'h1 << v));
            repeat ($urandom % 3) @(posedge clk_sys);
            fire(k);
            wait_take(40);
            chk({29'h0, taken_vec}, v);
            rdc(`OFS_IRQ_ENABLE, 32'h1 << v);
            rdc(`OFS_IRQ_FLAG, 32'h0);
            if (k > 4) rdc(`OFS_SOURCE_FLAG, 32'h1 << (k - 5));
            wr(`OFS_SOURCE_FLAG, 32'h0);
            ret();
        end
        $display("test sources done");
        lag <= 4'h0;
        wr(`OFS_IRQ_FLAG, 32'h81);
        wr(`OFS_IRQ_ENABLE, 32'h1FF);
        wait_take(40);
        chk({29'h0, taken_vec}, `VEC_CMP);
        wr(`OFS_IRQ_ENABLE, 32'h1FF);
        wait_take(40);
        chk({29'h0, taken_vec}, `VEC_SER);
        wr(`OFS_IRQ_FLAG, 32'h20);
        wr(`OFS_IRQ_ENABLE, 32'h1FF);
        xfer(1'b0, `OFS_VECTOR_STATUS, 32'h0);
        chk(rv[4:3], 2'h2);
        ret();
        wait_take(40);
        chk({29'h0, taken_vec}, `VEC_TB0);
        ret();
        ret();
        $display("test stack done");
        for (t = 0; t < 2; t++) begin
            for (s = 0; s < 3; s++) begin
                c = $urandom % 2;
                v = (s == 2) ? 2 + $urandom % 2 : s;
                wr(`OFS_PRESCALER0_CLOCK_SELECT + 8'(4 * t), ($urandom & 32'hFFFFFFFC) | v);
                rdc(`OFS_PRESCALER0_CLOCK_SELECT + 8'(4 * t), v);
                e = (s == 0) ? (256 << c) : (s == 1) ? (1024 << c) : ((256 << c) * 166) / 20;
                wr(`OFS_IRQ_ENABLE, 32'h100 | (32'h20 << t));
                wr(`OFS_TIME_BASE0_CONTROL + 8'(4 * t), 32'h80 | c);
                wait_take(10000);
                chk(n >= e - 10 && n <= e + 12, 1);
                chk({29'h0, taken_vec}, `VEC_TB0 + t);
                wr(`OFS_TIME_BASE0_CONTROL + 8'(4 * t), 32'h0);
                ret();
            end
        end
        $display("test time base done");
        give_verdict();
    end
endmodule
bind irq_timebase irq_timebase_monitor irq_timebase_monitor_i (.*);

// File: dv/irq_timebase_monitor.sv
// Concurrent checks on the bus side and vector outputs of the interrupt block
`timescale 1ns/1ps
module irq_timebase_monitor (
    input wire        clk_sys,
    input wire        reset_n,
    input wire        hsel,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire        hready,
    input wire [31:0] hrdata,
    input wire        hreadyout,
    input wire        hresp,
    input wire        stack_full,
    input wire        irq_ack,
    input wire        irq_request,
    input wire        irq_push_pc,
    input wire        reti_event
);
    logic rd_phase_ff;
    logic nxt_rd_phase;
    assign nxt_rd_phase = hsel && hready && htrans[1] && !hwrite;
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rd_phase_ff <= 1'b0;
        end else begin
            rd_phase_ff <= nxt_rd_phase;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    sequence rd_at(logic [7:0] a);
        nxt_rd_phase && haddr == {24'h0, a};
    endsequence
    // A push without a same-cycle return leaves global enable cleared
    sequence served;
        irq_push_pc && !reti_event;
    endsequence
    push_gate_a: assert property (irq_push_pc == (irq_request && irq_ack)) else $error("push without request and ack");
    full_block_a: assert property (stack_full |-> !irq_request) else $error("request while stack full");
    served_quiet_a: assert property (served |=> !irq_request) else $error("request right after service");
    unmapped_zero_a: assert property (rd_at(8'h40) |=> hrdata == 32'h0) else $error("unmapped read not zero");
    idle_zero_a: assert property (!rd_phase_ff |-> hrdata == 32'h0) else $error("read data outside data phase");
    psc_high_a: assert property (rd_at(8'h00) |=> hrdata[31:2] == 30'h0) else $error("selector upper bits set");
    ready_one_a: assert property (hreadyout == 1'b1) else $error("wait state inserted");
    okay_resp_a: assert property (hresp == 1'b0) else $error("error response");
    cover property (served);
endmodule

// File: logic/irq_timebase.v
// Interrupt request flags, enables, vector selection and two time-base interval generators
// ****************************************
// Overview of operation
// - Comparator output toggle sets comparator flag
// - Comparator vector needs global, local enable, stack
// - Comparator service clears its flag and global
// - Three groups fed by timer, voltage, memory
// - Voltage, memory or enabled timer event sets group flag
// - Group service clears group flag, global only
// - Conversion end sets converter flag, gated call
// - Converter service clears flag and global enable
// - Time-base overflow sets its request flag
// - Time-base call gated; service clears flag, global
// - Prescaler source: sys, sys/4, subsidiary clock
// - Time base runs only when bit7 set
// - Period is two to eight-plus-code clocks
// - Each timer raises A and P matches
// - Timer call needs global, timer, group enables
// - Timer service leaves timer match flags set
// - Serial byte, address match, timeout set flag
// - Serial call gated; service clears flag, global
// - Unused selector bits ignore writes, read zero
// - Full stack withholds request, flags kept
// - Taking interrupt pushes PC, loads vector
// ****************************************
`timescale 1ns/1ps
`include "irq_timebase_regs.vh"
module irq_timebase #(
    parameter NUM_TIMERS = 3
) (
    input  wire                    clk_sys,
    input  wire                    reset_n,
    input  wire                    hsel,
    input  wire [31:0]             haddr,
    input  wire [1:0]              htrans,
    input  wire                    hwrite,
    input  wire [2:0]              hsize,
    input  wire [31:0]             hwdata,
    input  wire                    hready,
    output reg  [31:0]             hrdata,
    output wire                    hreadyout,
    output wire                    hresp,
    input  wire                    comparator_out,
    input  wire                    converter_done,
    input  wire [2*NUM_TIMERS-1:0] timer_match,
    input  wire                    low_voltage_event,
    input  wire                    eeprom_done,
    input  wire                    serial_byte_done,
    input  wire                    serial_addr_match,
    input  wire                    serial_timeout,
    input  wire                    subsidiary_clock,
    input  wire                    stack_full,
    input  wire                    irq_ack,
    output wire                    irq_request,
    output wire [2:0]              irq_vector,
    output wire                    irq_push_pc,
    input  wire                    reti_event
);
    localparam NSRC = 2 * NUM_TIMERS + 2;
    // ****************************************
    // Reset and input synchronisation
    // ****************************************
    reg        rst_s1_ff;
    reg        rst_s2_ff;
    wire       rst_n = rst_s2_ff;
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rst_s1_ff <= 1'b0;
            rst_s2_ff <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_s2_ff <= rst_s1_ff;
        end
    end
    // Pins from other domains: comparator, subsidiary clock
    reg  [1:0] cmp_sync_ff;
    reg        cmp_last_ff;
    reg  [1:0] sub_sync_ff;
    reg        sub_last_ff;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cmp_sync_ff <= 2'h0;
            cmp_last_ff <= 1'b0;
            sub_sync_ff <= 2'h0;
            sub_last_ff <= 1'b0;
        end else begin
            cmp_sync_ff <= {cmp_sync_ff[0], comparator_out};
            cmp_last_ff <= cmp_sync_ff[1];
            sub_sync_ff <= {sub_sync_ff[0], subsidiary_clock};
            sub_last_ff <= sub_sync_ff[1];
        end
    end
    wire cmp_toggle = cmp_sync_ff[1] ^ cmp_last_ff;
    wire sub_rise   = sub_sync_ff[1] & ~sub_last_ff;
    // ****************************************
    // Registers
    // ****************************************
    reg  [1:0]      psc0_ff;
    reg  [1:0]      psc1_ff;
    reg             tb0_run_ff;
    reg             tb1_run_ff;
    reg  [2:0]      tb0_period_ff;
    reg  [2:0]      tb1_period_ff;
    reg  [8:0]      irq_en_ff;     // vector enables plus global enable
    reg  [7:0]      irq_flag_ff;
    reg  [NSRC-1:0] src_en_ff;     // timer A/P enables; low voltage, eeprom bits gate nothing
    reg  [NSRC-1:0] src_flag_ff;
    // ****************************************
    // AHB-Lite slave: zero wait states, always OKAY
    // ****************************************
    reg        wr_pend_ff;
    reg  [7:0] wr_addr_ff;
    reg        rd_pend_ff;
    reg  [7:0] rd_addr_ff;
    wire       take = hsel & hready & htrans[1];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
            rd_pend_ff <= 1'b0;
            rd_addr_ff <= 8'h00;
        end else begin
            wr_pend_ff <= take & hwrite;
            rd_pend_ff <= take & ~hwrite;
            wr_addr_ff <= haddr[7:0];
            rd_addr_ff <= haddr[7:0];
        end
    end
    function wr_hit;
        input [7:0] ofs;
        begin
            wr_hit = wr_pend_ff && (wr_addr_ff == ofs);
        end
    endfunction
    // Group membership per source: timers spread over groups, then voltage, eeprom to group 2
    function [1:0] group_of;
        input integer idx;
        begin
            // Cut to the two-bit group index on purpose
            if (idx < 2 * NUM_TIMERS)
                group_of = (((idx / 2) % 2) == 1) ? 2'h1 : 2'h0;
            else
                group_of = 2'h2;
        end
    endfunction
    // ****************************************
    // Time-base prescalers and interval counters
    // ****************************************
    reg  [1:0]  div4_ff;
    reg  [14:0] tb0_cnt_ff;
    reg  [14:0] tb1_cnt_ff;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            div4_ff <= 2'h0;
        else
            div4_ff <= div4_ff + 2'h1;
    end
    wire div4_tick = (div4_ff == `PSC_DIV4);
    function psc_tick;
        input [1:0] sel;
        input       d4;
        input       sub;
        begin
            if (sel[1])
                psc_tick = sub;
            else if (sel[0])
                psc_tick = d4;
            else
                psc_tick = 1'b1;
        end
    endfunction
    function [14:0] period_mask;
        input [2:0] code;
        begin
            period_mask = (15'h00FF << code) | 15'h00FF;
        end
    endfunction
    wire tb0_tick = tb0_run_ff & psc_tick(psc0_ff, div4_tick, sub_rise);
    wire tb1_tick = tb1_run_ff & psc_tick(psc1_ff, div4_tick, sub_rise);
    wire tb0_ovf  = tb0_tick && ((tb0_cnt_ff & period_mask(tb0_period_ff)) == period_mask(tb0_period_ff));
    wire tb1_ovf  = tb1_tick && ((tb1_cnt_ff & period_mask(tb1_period_ff)) == period_mask(tb1_period_ff));
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tb0_cnt_ff <= 15'h0000;
            tb1_cnt_ff <= 15'h0000;
        end else begin
            if (!tb0_run_ff)
                tb0_cnt_ff <= 15'h0000;
            else if (tb0_tick)
                tb0_cnt_ff <= tb0_cnt_ff + 15'h0001;
            if (!tb1_run_ff)
                tb1_cnt_ff <= 15'h0000;
            else if (tb1_tick)
                tb1_cnt_ff <= tb1_cnt_ff + 15'h0001;
        end
    end
    // ****************************************
    // Source flags of the groups
    // ****************************************
    wire [NSRC-1:0] src_event = {eeprom_done, low_voltage_event, timer_match};
    reg  [NSRC-1:0] nxt_src_flag;
    reg  [2:0]      grp_set;
    integer i;
    always @* begin
        nxt_src_flag = src_flag_ff;
        grp_set      = 3'h0;
        if (wr_hit(`OFS_SOURCE_FLAG))
            nxt_src_flag = hwdata[NSRC-1:0];
        for (i = 0; i < NSRC; i = i + 1) begin
            if (src_event[i]) begin
                nxt_src_flag[i] = 1'b1;
                // Timer requests also need their own enable to reach the group
                if (i >= 2 * NUM_TIMERS || src_en_ff[i])
                    grp_set[group_of(i)] = 1'b1;
            end
        end
    end
    // ****************************************
    // Vector flags, priority and service
    // ****************************************
    wire [7:0] vec_event = {serial_byte_done | serial_addr_match | serial_timeout,
                            tb1_ovf, tb0_ovf,
                            converter_done,
                            grp_set,
                            cmp_toggle};
    wire [7:0] pending = irq_flag_ff & irq_en_ff[7:0]
                         & {8{irq_en_ff[`GLOBAL_EN_BIT]}};
    reg  [2:0] sel_vec;
    integer k;
    always @* begin
        sel_vec = 3'h0;
        for (k = 7; k >= 0; k = k - 1)
            if (pending[k])
                sel_vec = k[2:0];
    end
    assign irq_request = (|pending) & ~stack_full;
    assign irq_vector  = sel_vec;
    assign irq_push_pc = irq_request & irq_ack;
    wire   service     = irq_request & irq_ack;
    reg  [7:0] nxt_irq_flag;
    reg  [8:0] nxt_irq_en;
    always @* begin
        nxt_irq_flag = irq_flag_ff;
        nxt_irq_en   = irq_en_ff;
        if (wr_hit(`OFS_IRQ_FLAG))
            nxt_irq_flag = hwdata[7:0];
        if (wr_hit(`OFS_IRQ_ENABLE))
            nxt_irq_en = hwdata[8:0];
        if (reti_event)
            nxt_irq_en[`GLOBAL_EN_BIT] = 1'b1;
        if (service) begin
            nxt_irq_flag[sel_vec]      = 1'b0;
            nxt_irq_en[`GLOBAL_EN_BIT] = 1'b0;
        end
        // Events win over any clear in the same cycle
        nxt_irq_flag = nxt_irq_flag | vec_event;
    end
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            psc0_ff       <= `RST_PSC;
            psc1_ff       <= `RST_PSC;
            tb0_run_ff    <= 1'b0;
            tb1_run_ff    <= 1'b0;
            tb0_period_ff <= `RST_TB_PERIOD;
            tb1_period_ff <= `RST_TB_PERIOD;
            irq_en_ff     <= 9'h000;
            irq_flag_ff   <= `RST_IRQ;
            src_en_ff     <= {NSRC{1'b0}};
            src_flag_ff   <= {NSRC{1'b0}};
        end else begin
            if (wr_hit(`OFS_PRESCALER0_CLOCK_SELECT))
                psc0_ff <= hwdata[`PSC_SEL_MSB:0];
            if (wr_hit(`OFS_PRESCALER1_CLOCK_SELECT))
                psc1_ff <= hwdata[`PSC_SEL_MSB:0];
            if (wr_hit(`OFS_TIME_BASE0_CONTROL)) begin
                tb0_run_ff    <= hwdata[`TB_RUN_BIT];
                tb0_period_ff <= hwdata[`TB_PERIOD_MSB:0];
            end
            if (wr_hit(`OFS_TIME_BASE1_CONTROL)) begin
                tb1_run_ff    <= hwdata[`TB_RUN_BIT];
                tb1_period_ff <= hwdata[`TB_PERIOD_MSB:0];
            end
            if (wr_hit(`OFS_SOURCE_ENABLE))
                src_en_ff <= hwdata[NSRC-1:0];
            irq_en_ff   <= nxt_irq_en;
            irq_flag_ff <= nxt_irq_flag;
            src_flag_ff <= nxt_src_flag;
        end
    end
    // ****************************************
    // Read data, decoded from the registered data-phase address
    // ****************************************
    reg [31:0] nxt_rdata;
    always @* begin
        nxt_rdata = 32'h0000_0000;
        if (rd_addr_ff == `OFS_PRESCALER0_CLOCK_SELECT)
            nxt_rdata[1:0] = psc0_ff;
        else if (rd_addr_ff == `OFS_PRESCALER1_CLOCK_SELECT)
            nxt_rdata[1:0] = psc1_ff;
        else if (rd_addr_ff == `OFS_TIME_BASE0_CONTROL)
            nxt_rdata[7:0] = {tb0_run_ff, 4'h0, tb0_period_ff};
        else if (rd_addr_ff == `OFS_TIME_BASE1_CONTROL)
            nxt_rdata[7:0] = {tb1_run_ff, 4'h0, tb1_period_ff};
        else if (rd_addr_ff == `OFS_IRQ_ENABLE)
            nxt_rdata[8:0] = irq_en_ff;
        else if (rd_addr_ff == `OFS_IRQ_FLAG)
            nxt_rdata[7:0] = irq_flag_ff;
        else if (rd_addr_ff == `OFS_SOURCE_ENABLE)
            nxt_rdata[NSRC-1:0] = src_en_ff;
        else if (rd_addr_ff == `OFS_SOURCE_FLAG)
            nxt_rdata[NSRC-1:0] = src_flag_ff;
        else if (rd_addr_ff == `OFS_VECTOR_STATUS)
            nxt_rdata[4:0] = {stack_full, irq_request, sel_vec};
    end
    // Read data is combinational from the data-phase address so it stands in the data phase
    always @* begin
        hrdata = rd_pend_ff ? nxt_rdata : 32'h0000_0000;
    end
endmodule

// File: logic/irq_timebase_regs.vh
// Register offsets, field positions and reset values of the interrupt and time-base block
`ifndef IRQ_TIMEBASE_REGS_VH
`define IRQ_TIMEBASE_REGS_VH
// ****************************************
// Register byte offsets
// ****************************************
`define OFS_PRESCALER0_CLOCK_SELECT 8'h00
`define OFS_PRESCALER1_CLOCK_SELECT 8'h04
`define OFS_TIME_BASE0_CONTROL      8'h08
`define OFS_TIME_BASE1_CONTROL      8'h0C
`define OFS_IRQ_ENABLE              8'h10
`define OFS_IRQ_FLAG                8'h14
`define OFS_SOURCE_ENABLE           8'h18
`define OFS_SOURCE_FLAG             8'h1C
`define OFS_VECTOR_STATUS           8'h20
// ****************************************
// Field positions
// ****************************************
`define TB_RUN_BIT                  7
`define TB_PERIOD_MSB               2
`define PSC_SEL_MSB                 1
// Interrupt enable / flag bit positions (vector index order, also priority)
`define VEC_CMP                     0
`define VEC_GRP0                    1
`define VEC_GRP1                    2
`define VEC_GRP2                    3
`define VEC_ADC                     4
`define VEC_TB0                     5
`define VEC_TB1                     6
`define VEC_SER                     7
`define GLOBAL_EN_BIT               8
// ****************************************
// Reset values and timing
// ****************************************
`define RST_PSC                     2'h0
`define RST_TB_PERIOD               3'h0
`define RST_IRQ                     8'h00
`define TB_BASE_EXP                 8
`define PSC_DIV4                    2'h3
`endif
